//--- rmvio_defines.vh
`ifndef RMVIO_DEFINES_VH
`define RMVIO_DEFINES_VH
// Matrix geometry.
`define RMVIO_NUM_SRC 53
`define RMVIO_NUM_OUT 72
`define RMVIO_SEL_W 6
`define RMVIO_SEL_BITS 432
`define RMVIO_MAX_CODE 6'h34
// Source codes with fixed meaning.
`define RMVIO_SRC_GND 6'h00
`define RMVIO_SRC_VIRT_FIRST 6'h18
`define RMVIO_SRC_CMP0 6'h2d
`define RMVIO_SRC_OSC1 6'h31
`define RMVIO_SRC_READY 6'h32
`define RMVIO_SRC_POR 6'h33
`define RMVIO_SRC_VDD 6'h34
// Virtual input count and the pin-shared subset start.
`define RMVIO_NUM_VIRT 15
`define RMVIO_VIRT_PIN_FIRST 6
// Serial byte addresses.
`define RMVIO_ADDR_RB_FIRST 8'h36
`define RMVIO_ADDR_VIRT_LO 8'h39
`define RMVIO_ADDR_VIRT_HI 8'h3a
`define RMVIO_ADDR_RB_LAST 8'h3c
// Byte 0x36 holds config bit 432; virtual bits 456..470 lie in bytes 0x39/0x3a.
`define RMVIO_RB_BASE_BIT 432
`define RMVIO_VIRT_HI_MASK 8'h7f
`endif

//--- rmvio_matrix.v
`timescale 1ns/1ps
`include "rmvio_defines.vh"
// Function
// - Each output picks one of 53 sources.
// - Codes 45-51: comparator, oscillator, ready, reset.
// - Outputs take consecutive six-bit configuration slices.
// - Outputs 4,5 feed third two-input cell.
// - Outputs 18-29 feed four three-input cells.
// - Outputs 30-32 double as state machine inputs.
// - Outputs 48-51 feed the four-input cell.
// - Outputs 52,53 feed delay and filter inputs.
// - Outputs 54-66 drive pins and enables.
// - Outputs 67-69 comparator and oscillator controls.
// - Outputs 70,71 clock and clear pattern generator.
// - Virtual bits sit in bytes 0x39, 0x3a.
// - Writes change virtual source level at once, except in a startup load cycle, where the load wins.
// - Reads return startup value or last write.
// - Selector bits choose pin or pattern output, or virtual bit.
// - Virtual bits map to sources 24-38.
// - Virtual lines shared with pattern and pins.
// - Macrocell outputs readable in bytes 0x36-0x3c.
// - Writes to read-back bits are ignored.
module rmvio_matrix (
  input wire i_clk, // System clock.
  input wire i_rst, // Asynchronous reset, active high.
  input wire i_cfg_load, // One-cycle pulse: startup configuration valid.
  input wire [431:0] i_cfg_sel, // Select fields, outputs 0..71.
  input wire [14:0] i_cfg_virt_init, // Startup virtual values, bits 456..470.
  input wire [7:0] i_cfg_virt_mode, // Mode selects, bits 1072..1078 and 1184 at top.
  input wire [23:0] i_mc_out, // Macrocell outputs, sources 1..23.
  input wire [7:0] i_pattern_out, // Extended pattern generator outputs.
  input wire [8:0] i_pin_in, // Bidirectional pin inputs, pins 0..8.
  input wire i_in_only_pin, // Input-only pin level, source 40.
  input wire i_four_input_cell, // Four-input cell output, source 39.
  input wire [2:0] i_edge_misc, // Delay edge, filter, oscillator 0 output, sources 41..43.
  input wire i_osc1_out, // Second oscillator output, source 44.
  input wire [3:0] i_cmp_result, // Multichannel comparator results.
  input wire i_osc_out_b, // Second slow-oscillator output.
  input wire i_cmp_ready, // Comparator result ready strobe.
  input wire i_por, // Power-on reset signal.
  input wire i_wr_en, // One-cycle serial write strobe.
  input wire i_rd_en, // One-cycle serial read strobe.
  input wire [7:0] i_addr, // Serial byte address.
  input wire [7:0] i_wdata, // Serial write data.
  output reg [7:0] o_rdata_q, // Read data, valid the cycle after i_rd_en.
  output reg o_rvalid_q, // Read data valid pulse.
  output reg [3:0] o_cell_c_q, // Outputs 4,5 and spare to third two-input cell.
  output reg [11:0] o_three_cell_q, // Outputs 18..29, three-input cells.
  output reg [2:0] o_state_machine_q, // Outputs 30..32.
  output reg [3:0] o_four_input_cell_q, // Outputs 48..51.
  output reg [1:0] o_edge_in_q, // Outputs 52,53.
  output reg [8:0] o_pin_out_q, // Pin output values, outputs 54..65.
  output reg [3:0] o_pin_oe_q, // Pin enables, outputs 57,59,64,66.
  output reg [2:0] o_cmp_ctrl_q, // Outputs 67..69.
  output reg [1:0] o_pattern_ctrl_q, // Outputs 70,71.
  output reg [71:0] o_matrix_q // All matrix outputs.
);
  wire [52:0] src;
  wire [71:0] mx;
  wire [14:0] virt;
  wire [14:0] shared_line;
  wire [14:0] use_virt;
  wire [14:0] base_line;
  wire [7:0] rd_byte;
  wire wr_lo;
  wire wr_hi;
  genvar gi;

  // Returns the select field for output n from its configuration slice.
  function [5:0] sel_of;
    input [431:0] cfg;
    input integer n;
    begin
      sel_of = cfg[n*6 +: 6];
    end
  endfunction

  // True when a write strobe targets one byte address; both virtual bytes decode this way.
  function write_hits;
    input wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      write_hits = wr && (addr == target);
    end
  endfunction

  // Writes reach only the two virtual bytes; other read-back bytes drop writes.
  assign wr_lo = write_hits(i_wr_en, i_addr, `RMVIO_ADDR_VIRT_LO);
  assign wr_hi = write_hits(i_wr_en, i_addr, `RMVIO_ADDR_VIRT_HI);

  rmvio_virt u_virt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(i_cfg_load),
    .i_init(i_cfg_virt_init),
    .i_wr_lo(wr_lo),
    .i_wr_hi(wr_hi),
    .i_wdata(i_wdata),
    .o_virt_q(virt)
  );

  // Lines 0..5 default to pattern outputs 0..5, 6..14 to pins 0..8; pattern outputs 6,7 feed no line.
  assign base_line[5:0] = i_pattern_out[5:0];
  assign base_line[14:6] = i_pin_in;
  // One mode bit per line for lines 0..6 (bits 1072..1078); bit 1184 covers lines 7..14.
  generate
    for (gi = 0; gi < `RMVIO_NUM_VIRT; gi = gi + 1) begin : g_share
      if (gi < 7) begin : g_lo
        assign use_virt[gi] = i_cfg_virt_mode[gi];
      end else begin : g_hi
        assign use_virt[gi] = i_cfg_virt_mode[7];
      end
      assign shared_line[gi] = use_virt[gi] ? virt[gi] : base_line[gi];
    end
  endgenerate

  // Source list in code order.
  assign src[0] = 1'b0;
  assign src[23:1] = i_mc_out[22:0];
  assign src[38:24] = shared_line;
  assign src[39] = i_four_input_cell;
  assign src[40] = i_in_only_pin;
  assign src[43:41] = i_edge_misc;
  assign src[44] = i_osc1_out;
  assign src[48:45] = i_cmp_result;
  assign src[49] = i_osc_out_b;
  assign src[50] = i_cmp_ready;
  assign src[51] = i_por;
  assign src[52] = 1'b1;

  // One selector per matrix output.
  generate
    for (gi = 0; gi < `RMVIO_NUM_OUT; gi = gi + 1) begin : g_mux
      rmvio_mux u_mux (
        .i_src(src),
        .i_sel(sel_of(i_cfg_sel, gi)),
        .o_out(mx[gi])
      );
    end
  endgenerate

  // Read-back decode. The virtual bytes answer from the stored bits, so a read returns the
  // last write even while the line itself follows a pin or a pattern output.
  function [7:0] read_back;
    input [7:0] addr;
    input [52:0] lines;
    input [14:0] vbits;
    begin
      case (addr)
        `RMVIO_ADDR_RB_FIRST: read_back = lines[7:0];
        8'h37: read_back = lines[15:8];
        8'h38: read_back = lines[23:16];
        `RMVIO_ADDR_VIRT_LO: read_back = vbits[7:0];
        `RMVIO_ADDR_VIRT_HI: read_back = {1'b0, vbits[14:8]};
        8'h3b: read_back = lines[46:39];
        `RMVIO_ADDR_RB_LAST: read_back = {3'h0, lines[51:47]};
        default: read_back = 8'h00;
      endcase
    end
  endfunction

  // Byte 0x3a keeps seven bits only, so its top bit reads as zero; unmapped bytes read zero.
  assign rd_byte = read_back(i_addr, src, virt);

  // The answer holds between reads, so a master that samples late still sees its byte.
  wire [7:0] rdata_d;
  assign rdata_d = i_rd_en ? rd_byte : o_rdata_q;

  // Read data register, loaded one cycle after the strobe.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata_q <= 8'h00;
    end else begin
      o_rdata_q <= rdata_d;
    end
  end

  // Read valid pulses for exactly one cycle per accepted read strobe.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid_q <= 1'b0;
    end else begin
      o_rvalid_q <= i_rd_en;
    end
  end

  // Next values of the grouped outputs, one group per kind of destination.
  // Every group takes selector outputs with no logic between (spare cell_c_d bits tied low); the flops add one cycle.
  wire [3:0] cell_c_d;
  wire [11:0] three_cell_d;
  wire [2:0] state_machine_d;
  wire [3:0] four_input_cell_d;
  wire [1:0] edge_in_d;
  wire [8:0] pin_out_d;
  wire [3:0] pin_oe_d;
  wire [2:0] cmp_ctrl_d;
  wire [1:0] pattern_ctrl_d;

  // Third two-input cell: two inputs, or clock and active-low clear; spare bits stay low.
  assign cell_c_d[0] = mx[4];
  assign cell_c_d[1] = mx[5];
  assign cell_c_d[3:2] = 2'h0;

  // Four three-input cells, three matrix outputs each: clock, data, active-low set or clear.
  assign three_cell_d[2:0] = mx[20:18];
  assign three_cell_d[5:3] = mx[23:21];
  assign three_cell_d[8:6] = mx[26:24];
  assign three_cell_d[11:9] = mx[29:27];

  // State machine: up input, shared external clock, reset or set input.
  assign state_machine_d[0] = mx[30];
  assign state_machine_d[1] = mx[31];
  assign state_machine_d[2] = mx[32];

  // Four-input cell; in flip-flop use the first three are clock, data and clear.
  assign four_input_cell_d[0] = mx[48];
  assign four_input_cell_d[1] = mx[49];
  assign four_input_cell_d[2] = mx[50];
  assign four_input_cell_d[3] = mx[51];

  // Delay edge-detect input and filter edge-detect input.
  assign edge_in_d[0] = mx[52];
  assign edge_in_d[1] = mx[53];

  // Pin output values skip the three enable selects that sit between them.
  assign pin_out_d[0] = mx[54];
  assign pin_out_d[1] = mx[55];
  assign pin_out_d[2] = mx[56];
  assign pin_out_d[3] = mx[58];
  assign pin_out_d[4] = mx[60];
  assign pin_out_d[5] = mx[61];
  assign pin_out_d[6] = mx[62];
  assign pin_out_d[7] = mx[63];
  assign pin_out_d[8] = mx[65];

  // Drive enables of the four pins whose enable is routed, in pin order.
  assign pin_oe_d[0] = mx[57];
  assign pin_oe_d[1] = mx[59];
  assign pin_oe_d[2] = mx[64];
  assign pin_oe_d[3] = mx[66];

  // Comparator enable, comparator result clear, oscillator enable.
  assign cmp_ctrl_d[0] = mx[67];
  assign cmp_ctrl_d[1] = mx[68];
  assign cmp_ctrl_d[2] = mx[69];

  // Extended pattern generator clock and its active-low clear.
  assign pattern_ctrl_d[0] = mx[70];
  assign pattern_ctrl_d[1] = mx[71];

  // Output registers. Every top output comes straight from a flop, at the cost of one cycle
  // of routing latency; clearing them in reset keeps each destination idle while i_rst
  // is held.
  // All matrix outputs side by side, for read-out and for checking.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_matrix_q <= 72'h0;
    end else begin
      o_matrix_q <= mx;
    end
  end

  // Third two-input cell inputs.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cell_c_q <= 4'h0;
    end else begin
      o_cell_c_q <= cell_c_d;
    end
  end

  // Three-input cell inputs.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_three_cell_q <= 12'h000;
    end else begin
      o_three_cell_q <= three_cell_d;
    end
  end

  // State machine inputs.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_state_machine_q <= 3'h0;
    end else begin
      o_state_machine_q <= state_machine_d;
    end
  end

  // Four-input cell inputs.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_four_input_cell_q <= 4'h0;
    end else begin
      o_four_input_cell_q <= four_input_cell_d;
    end
  end

  // Edge-detect inputs.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_edge_in_q <= 2'h0;
    end else begin
      o_edge_in_q <= edge_in_d;
    end
  end

  // Pin output values.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out_q <= 9'h000;
    end else begin
      o_pin_out_q <= pin_out_d;
    end
  end

  // Pin enables stay low in reset, so no pin drives before it has been routed.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_oe_q <= 4'h0;
    end else begin
      o_pin_oe_q <= pin_oe_d;
    end
  end

  // Comparator and oscillator controls rest low, so both stay off during reset.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmp_ctrl_q <= 3'h0;
    end else begin
      o_cmp_ctrl_q <= cmp_ctrl_d;
    end
  end

  // Pattern generator clock and clear.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pattern_ctrl_q <= 2'h0;
    end else begin
      o_pattern_ctrl_q <= pattern_ctrl_d;
    end
  end
endmodule // rmvio_matrix

//--- rmvio_matrix_properties.sv
`timescale 1ns/1ps
// Ties routed outputs and read answers to their causes at the inputs.
module rmvio_matrix_properties (
  input wire i_clk, // Clock.
  input wire i_rst, // Reset.
  input wire i_cfg_load, // Startup load.
  input wire [431:0] i_cfg_sel, // Select fields.
  input wire [7:0] i_cfg_virt_mode, // Line modes.
  input wire i_cmp_ready, // Ready strobe.
  input wire i_por, // Power-on reset.
  input wire i_wr_en, // Write strobe.
  input wire i_rd_en, // Read strobe.
  input wire [7:0] i_addr, // Address.
  input wire [7:0] i_wdata, // Write data.
  input wire [7:0] o_rdata_q, // Read data.
  input wire o_rvalid_q, // Read valid.
  input wire [3:0] o_cell_c_q, // Third two-input cell.
  input wire [2:0] o_state_machine_q, // State machine inputs.
  input wire [3:0] o_pin_oe_q, // Pin enables.
  input wire [71:0] o_matrix_q // All outputs.
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // A read request is one step; its answer lands on the next edge.
  sequence s_read(a);
    i_rd_en && i_addr == a;
  endsequence
  // A write to the low virtual byte while output 2 listens to line 0.
  sequence s_virt_write;
    i_wr_en && i_addr == 8'h39 && !i_cfg_load && i_cfg_virt_mode[0] && i_cfg_sel[17:12] == 6'h18;
  endsequence
  a_rvalid_pulse: assert property (i_rd_en |=> o_rvalid_q) else $error("read answer missing");
  a_rvalid_one: assert property (!i_rd_en |=> !o_rvalid_q) else $error("read valid without request");
  a_unmapped_zero: assert property (i_rd_en && (i_addr < 8'h36 || i_addr > 8'h3c) |=> o_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_hi_top_zero: assert property (s_read(8'h3a) |=> !o_rdata_q[7]) else $error("bit 7 of high byte set");
  a_gnd_readback: assert property (s_read(8'h36) |=> !o_rdata_q[0]) else $error("ground reads high");
  a_ready_route: assert property (i_cfg_sel[5:0] == 6'h32 |=> o_matrix_q[0] == $past(i_cmp_ready))
    else $error("ready line misrouted");
  a_por_route: assert property (i_cfg_sel[431:426] == 6'h33 |=> o_matrix_q[71] == $past(i_por))
    else $error("reset line misrouted");
  a_bad_code_low: assert property (i_cfg_sel[23:18] > 6'h34 |=> !o_matrix_q[3]) else $error("bad code not low");
  a_virt_write: assert property (s_virt_write |=> ##1 o_matrix_q[2] == $past(i_wdata[0], 2))
    else $error("virtual write not routed");
  a_oe_group: assert property (o_pin_oe_q == {o_matrix_q[66], o_matrix_q[64], o_matrix_q[59], o_matrix_q[57]})
    else $error("pin enables wrong");
  a_cell_c_group: assert property (o_cell_c_q == {2'b00, o_matrix_q[5:4]}) else $error("cell inputs wrong");
  a_sm_group: assert property (o_state_machine_q == o_matrix_q[32:30]) else $error("sm inputs wrong");
endmodule // rmvio_matrix_properties
bind rmvio_matrix rmvio_matrix_properties u_props (.i_clk, .i_rst, .i_cfg_load, .i_cfg_sel, .i_cfg_virt_mode,
  .i_cmp_ready, .i_por, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata_q, .o_rvalid_q, .o_cell_c_q,
  .o_state_machine_q, .o_pin_oe_q, .o_matrix_q);

//--- rmvio_matrix_tb_top.sv
`timescale 1ns/1ps
module rmvio_matrix_tb_top;
  logic i_clk = 1'b0, i_rst = 1'b1, i_cfg_load = 1'b0;
  logic [431:0] i_cfg_sel = '0;
  logic [14:0] i_cfg_virt_init = 15'h5a3c, vexp;
  logic [7:0] i_cfg_virt_mode = 8'hff, i_pattern_out = 8'h96, i_addr, i_wdata, o_rdata_q, rb;
  logic [23:0] i_mc_out = 24'h9a5c33;
  logic [8:0] i_pin_in = 9'h14b;
  logic [2:0] i_edge_misc = 3'h5;
  logic [3:0] i_cmp_result = 4'h9;
  logic i_in_only_pin = 1'b1, i_four_input_cell = 1'b0, i_osc1_out = 1'b1, i_osc_out_b = 1'b0;
  logic i_cmp_ready = 1'b1, i_por = 1'b0, i_wr_en, i_rd_en, o_rvalid_q, rv;
  logic [71:0] o_matrix_q;
  logic [3:0] o_cell_c_q, o_four_input_cell_q, o_pin_oe_q;
  logic [11:0] o_three_cell_q;
  logic [2:0] o_state_machine_q, o_cmp_ctrl_q;
  logic [1:0] o_edge_in_q, o_pattern_ctrl_q;
  logic [8:0] o_pin_out_q;
  int fails = 0, n_compared = 0;
  always #50 i_clk = ~i_clk;
  rmvio_serial_master m (.i_clk, .i_rdata(o_rdata_q), .i_rvalid(o_rvalid_q), .o_wr_en(i_wr_en),
    .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));
  rmvio_matrix dut (.i_clk, .i_rst, .i_cfg_load, .i_cfg_sel, .i_cfg_virt_init, .i_cfg_virt_mode, .i_mc_out,
    .i_pattern_out, .i_pin_in, .i_in_only_pin, .i_four_input_cell, .i_edge_misc, .i_osc1_out, .i_cmp_result,
    .i_osc_out_b, .i_cmp_ready, .i_por, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata_q, .o_rvalid_q,
    .o_cell_c_q, .o_three_cell_q, .o_state_machine_q, .o_four_input_cell_q, .o_edge_in_q,
    .o_pin_out_q, .o_pin_oe_q, .o_cmp_ctrl_q, .o_pattern_ctrl_q, .o_matrix_q);
  task automatic check(input logic [71:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rx(input logic [7:0] a, exp);
    m.rd(a, rb, rv);
    check({rv, rb}, {1'b1, exp});
  endtask
  // Expected level of a source line; lines 6 and up fall back to pins, not patterns.
  function automatic logic src(input int c);
    logic [52:0] s;
    logic [14:0] alt;
    alt = {i_pin_in, i_pattern_out[5:0]};
    s[23:0] = {i_mc_out[22:0], 1'b0};
    for (int k = 0; k < 15; k++) s[24 + k] = ((k < 7) ? i_cfg_virt_mode[k] : i_cfg_virt_mode[7]) ? vexp[k] : alt[k];
    s[52:39] = {1'b1, i_por, i_cmp_ready, i_osc_out_b, i_cmp_result, i_osc1_out, i_edge_misc, i_in_only_pin,
      i_four_input_cell};
    return (c > 52) ? 1'b0 : s[c];
  endfunction
  // Outputs get consecutive codes modulo 64, so outputs n and n+64 share one; over one pass all 64 codes appear.
  task automatic route(input int off, input logic [7:0] mode);
    logic [71:0] e;
    i_cfg_virt_mode = mode;
    for (int n = 0; n < 72; n++) i_cfg_sel[6 * n +: 6] = 6'((n + off) % 64);
    repeat (2) @(posedge i_clk);
    #1;
    for (int n = 0; n < 72; n++) e[n] = src((n + off) % 64);
    for (int n = 0; n < 72; n++) check(o_matrix_q[n], e[n]);
    check(o_cell_c_q, {2'b00, e[5:4]});
    check(o_three_cell_q, e[29:18]);
    check(o_state_machine_q, e[32:30]);
    check(o_four_input_cell_q, e[51:48]);
    check(o_edge_in_q, e[53:52]);
    check(o_pin_out_q, {e[65], e[63:60], e[58], e[56:54]});
    check(o_pin_oe_q, {e[66], e[64], e[59], e[57]});
    check(o_cmp_ctrl_q, e[69:67]);
    check(o_pattern_ctrl_q, e[71:70]);
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog sized at several times the expected run of under a hundred cycles.
  initial begin
    #50000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    #1 {i_rst, i_cfg_load} = 2'b01;
    @(posedge i_clk);
    #1 i_cfg_load = 1'b0;
    vexp = i_cfg_virt_init;
    i_cfg_sel = {72{6'h18}};
    rx(8'h39, 8'h3c);
    rx(8'h3a, 8'h5a);
    m.wr(8'h39, 8'ha5);
    m.wr(8'h3a, 8'hff);
    rx(8'h39, 8'ha5);
    rx(8'h3a, 8'h7f);
    m.wr(8'h39, 8'h5a);
    check(o_matrix_q, {72{1'b1}});
    @(posedge i_clk);
    #1 check(o_matrix_q, 72'h0);
    vexp = 15'h7f5a;
    $display("test virtual done");
    m.wr(8'h36, 8'hff);
    rx(8'h36, {i_mc_out[6:0], 1'b0});
    rx(8'h39, 8'h5a);
    rx(8'h37, i_mc_out[14:7]);
    rx(8'h38, i_mc_out[22:15]);
    rx(8'h3b, {i_cmp_result[1:0], i_osc1_out, i_edge_misc, i_in_only_pin, i_four_input_cell});
    rx(8'h3c, {3'h0, i_por, i_cmp_ready, i_osc_out_b, i_cmp_result[3:2]});
    rx(8'h40, 8'h00);
    $display("test readback done");
    route(50, 8'h55);
    {i_mc_out, i_pattern_out, i_pin_in, i_edge_misc, i_cmp_result} = ~{i_mc_out, i_pattern_out, i_pin_in,
      i_edge_misc, i_cmp_result};
    {i_in_only_pin, i_four_input_cell, i_osc1_out, i_osc_out_b, i_cmp_ready, i_por} = 6'h16;
    route(44, 8'haa);
    $display("test routing done");
    give_verdict();
  end
endmodule // rmvio_matrix_tb_top

//--- rmvio_mux.v
`timescale 1ns/1ps
`include "rmvio_defines.vh"
// One matrix output: picks one source line by its select code.
module rmvio_mux (
  input wire [52:0] i_src, // All matrix source lines.
  input wire [5:0] i_sel, // Select code.
  output wire o_out // Selected level.
);
  // Codes above the last source give a constant low rather than an unknown.
  assign o_out = (i_sel > `RMVIO_MAX_CODE) ? 1'b0 : i_src[i_sel];
endmodule // rmvio_mux

//--- rmvio_serial_master.sv
`timescale 1ns/1ps
// Serial master stand-in issuing one-cycle byte requests.
module rmvio_serial_master (
  input wire i_clk, // Clock.
  input wire [7:0] i_rdata, // Read data.
  input wire i_rvalid, // Read valid.
  output logic o_wr_en = 1'b0, // Write strobe.
  output logic o_rd_en = 1'b0, // Read strobe.
  output logic [7:0] o_addr = 8'h00, // Address.
  output logic [7:0] o_wdata = 8'h00 // Write data.
);
  // Released lines flip so that a stale value is never mistaken for a held one.
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_clk);
    #1 {o_wr_en, o_addr, o_wdata} = {1'b1, a, d};
    @(posedge i_clk);
    #1 {o_wr_en, o_addr, o_wdata} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clk);
    #1 {o_rd_en, o_addr} = {1'b1, a};
    @(posedge i_clk);
    #1 {d, v} = {i_rdata, i_rvalid};
    {o_rd_en, o_addr} = {1'b0, ~a};
  endtask
endmodule // rmvio_serial_master

//--- rmvio_virt.v
`timescale 1ns/1ps
// Serially writable virtual input bits with startup values.
module rmvio_virt (
  input wire i_clk, // System clock.
  input wire i_rst, // Asynchronous reset, active high.
  input wire i_load, // One-cycle pulse copying startup values.
  input wire [14:0] i_init, // Startup values from nonvolatile memory.
  input wire i_wr_lo, // Write strobe for byte holding bits 0..7.
  input wire i_wr_hi, // Write strobe for byte holding bits 8..14.
  input wire [7:0] i_wdata, // Write data.
  output reg [14:0] o_virt_q // Current virtual bits.
);
  // A write updates the stored level at once unless i_load is high in that cycle, when the load wins; the load only runs at startup.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_virt_q <= 15'h0000;
    end else if (i_load) begin
      o_virt_q <= i_init;
    end else begin
      if (i_wr_lo) begin
        o_virt_q[7:0] <= i_wdata;
      end
      if (i_wr_hi) begin
        o_virt_q[14:8] <= i_wdata[6:0];
      end
    end
  end
endmodule // rmvio_virt
